// ==== src/isa_cycle_defines.svh ====
`ifndef ISA_CYCLE_DEFINES_SVH
`define ISA_CYCLE_DEFINES_SVH

// clock and command timing
`define CLK_PERIOD_NS 5
`define CMD_MIN_NS 100
`define CMD_MIN_CYCLES ((`CMD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMD_CNT_W 5

// data store layout
`define STORE_BYTE_W 8
`define STORE_LO 1'b0
`define STORE_HI 1'b1

`endif

// ==== src/isa_cycle_pkg.sv ====
package isa_cycle_pkg;

    typedef enum logic [1:0] {
        KIND_MEM_RD = 2'h0,
        KIND_MEM_WR = 2'h1,
        KIND_IO_RD = 2'h2,
        KIND_IO_WR = 2'h3
    } kind_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ADDR = 5'h02,
        ST_CMD = 5'h04,
        ST_END = 5'h08,
        ST_DONE = 5'h10
    } state_t;

endpackage

// ==== src/rdata_store.sv ====
`timescale 1ns/1ps
`include "isa_cycle_defines.svh"

module rdata_store
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // byte write port
    input wire logic i_we,
    input wire logic i_sel,
    input wire logic [7:0] i_wdata,
    input wire logic i_we_both,
    input wire logic [15:0] i_wdata_both,
    // registered read
    output logic [15:0] o_rdata
);
    logic [7:0] mem_q [0:1];
    logic [7:0] mem_d [0:1];
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;

    always_comb
    begin
        mem_d[0] = mem_q[0];
        mem_d[1] = mem_q[1];
        if (i_we_both)
        begin
            mem_d[0] = i_wdata_both[7:0];
            mem_d[1] = i_wdata_both[15:8];
        end
        else if (i_we)
        begin
            if (i_sel == `STORE_HI)
                mem_d[1] = i_wdata;
            else
                mem_d[0] = i_wdata;
        end
        // write-through so the answer is ready with the done pulse
        rdata_d = {mem_d[1], mem_d[0]};
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            mem_q[0] <= 8'h00;
            mem_q[1] <= 8'h00;
            rdata_q <= 16'h0000;
        end
        else
        begin
            mem_q[0] <= mem_d[0];
            mem_q[1] <= mem_d[1];
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;
endmodule

// ==== src/isa_bus_cycle_control.sv ====
// Behaviour
// R1: raise address enable on every DMA cycle
// R2: peripherals ignore I/O cycles while enabled
// R3: DMA acknowledge selects peripheral during enable
// R4: address enable also for internal DMA
// R5: address enable on every card I/O access
// R6: latch enable pulses when address valid
// R7: latch enable on card and DMA cycles
// R8: transceiver enable in local/32-bit DRAM modes
// R9: separate direction controls per data byte
// R10: ready low stretches the current command
// R11: peripherals drive ready open-drain only
// R12: I/O 16-bit select gives wide access
// R13: memory 16-bit select gives wide access
// R14: I/O read command gates peripheral drive
// R15: I/O write command, peripheral latches data
// R16: byte-high enable when upper lanes used
// R17: memory read command gates memory drive
// R18: no select means split byte cycles
`timescale 1ns/1ps
`include "isa_cycle_defines.svh"

module isa_bus_cycle_control
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // internal request
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire logic [1:0] i_req_kind,
    input wire logic [25:0] i_req_addr,
    input wire logic [15:0] i_req_wdata,
    input wire logic i_req_wide,
    input wire logic i_req_dma,
    input wire logic i_req_dma_internal,
    input wire logic i_req_dma_chan,
    input wire logic i_req_card_io,
    // completion
    output logic o_done,
    output logic [15:0] o_rdata,
    // modes
    input wire logic i_local_bus_mode,
    input wire logic i_dram32_mode,
    // bus control pins
    output logic o_aen,
    output logic o_bale,
    output logic o_ior_n,
    output logic o_iow_n,
    output logic o_memr_n,
    output logic o_memw_n,
    output logic o_sbhe_n,
    output logic [1:0] o_prog_dma_ack_n,
    output logic [25:0] o_sa,
    // data pins
    input wire logic [15:0] i_sd,
    output logic [15:0] o_sd,
    output logic o_sd_oe,
    // peripheral answers
    input wire logic i_iochrdy,
    input wire logic i_iocs16_n,
    input wire logic i_mem_wide_select_n,
    // transceiver control
    output logic o_xcvr_output_enable_n,
    output logic o_xcvr_dir_high_byte,
    output logic o_xcvr_dir_low_byte
);
    isa_cycle_pkg::state_t state_q, state_d;
    isa_cycle_pkg::kind_t kind_q, kind_d;
    logic [25:0] addr_q, addr_d;
    logic [15:0] wdata_q, wdata_d;
    logic [`CMD_CNT_W-1:0] cnt_q, cnt_d;
    logic req_wide_q, req_wide_d, dev16_q, dev16_d, phase_q, phase_d;
    logic dma_q, dma_d, dma_int_q, dma_int_d, dma_chan_q, dma_chan_d, card_io_q, card_io_d;
    logic aen_q, aen_d, bale_q, bale_d, ior_q, ior_d, iow_q, iow_d, memr_q, memr_d;
    logic memw_q, memw_d, sbhe_q, sbhe_d, sd_oe_q, sd_oe_d;
    logic xoe_q, xoe_d, xdh_q, xdh_d, xdl_q, xdl_d;
    logic [1:0] dack_q, dack_d;
    logic [15:0] sd_q, sd_d;
    logic [7:0] st_byte;
    logic st_we, st_we_both, st_sel, full16, hi_lane, wide_sel, in_cycle, rd, commands_on;

    function automatic logic is_read(input isa_cycle_pkg::kind_t k);
        is_read = (k == isa_cycle_pkg::KIND_MEM_RD) || (k == isa_cycle_pkg::KIND_IO_RD);
    endfunction
    function automatic logic is_io(input isa_cycle_pkg::kind_t k);
        is_io = (k == isa_cycle_pkg::KIND_IO_RD) || (k == isa_cycle_pkg::KIND_IO_WR);
    endfunction

    // width flags of the transfer in flight
    assign full16 = req_wide_q && dev16_q;
    assign hi_lane = !req_wide_q && dev16_q && addr_q[0];
    assign rd = is_read(kind_q);
    // internal DMA owns the bus for address and latch enable, with no commands or captures
    assign commands_on = !dma_int_q; // R4
    assign wide_sel = is_io(kind_q) ? !i_iocs16_n : !i_mem_wide_select_n; // R12 R13

    always_comb
    begin
        state_d = state_q;
        kind_d = kind_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        cnt_d = cnt_q;
        req_wide_d = req_wide_q;
        dev16_d = dev16_q;
        phase_d = phase_q;
        dma_d = dma_q;
        dma_int_d = dma_int_q;
        dma_chan_d = dma_chan_q;
        card_io_d = card_io_q;
        st_we = 1'b0;
        st_we_both = 1'b0;
        st_sel = `STORE_LO;
        st_byte = i_sd[7:0];
        case (state_q)
            isa_cycle_pkg::ST_IDLE:
            begin
                if (i_req_valid)
                begin
                    kind_d = isa_cycle_pkg::kind_t'(i_req_kind);
                    addr_d = i_req_addr;
                    wdata_d = i_req_wdata;
                    req_wide_d = i_req_wide;
                    dma_d = i_req_dma || i_req_dma_internal;
                    dma_int_d = i_req_dma_internal;
                    dma_chan_d = i_req_dma_chan;
                    card_io_d = i_req_card_io;
                    phase_d = 1'b0;
                    dev16_d = 1'b0;
                    state_d = isa_cycle_pkg::ST_ADDR;
                end
            end
            isa_cycle_pkg::ST_ADDR:
            begin
                // select lines are sampled early, before the command
                dev16_d = wide_sel && !phase_q; // R12 R13 R18
                cnt_d = `CMD_CNT_W'(`CMD_MIN_CYCLES - 1);
                state_d = isa_cycle_pkg::ST_CMD;
            end
            isa_cycle_pkg::ST_CMD:
            begin
                if (cnt_q != '0)
                    cnt_d = cnt_q - `CMD_CNT_W'(1);
                else if (i_iochrdy) // R10
                begin
                    // capture while the command still lets the target drive
                    state_d = isa_cycle_pkg::ST_END;
                    st_we_both = rd && full16; // R14 R17
                    st_we = rd && !full16;
                    st_sel = phase_q || hi_lane;
                    st_byte = hi_lane ? i_sd[15:8] : i_sd[7:0];
                end
            end
            isa_cycle_pkg::ST_END:
            begin
                if (req_wide_q && !dev16_q && !phase_q)
                begin
                    // second byte of a split word on the low lanes
                    phase_d = 1'b1; // R18
                    addr_d = addr_q + 26'h0000001;
                    state_d = isa_cycle_pkg::ST_ADDR;
                end
                else
                    state_d = isa_cycle_pkg::ST_DONE;
            end
            default: // done and stray codes return to idle
                state_d = isa_cycle_pkg::ST_IDLE;
        endcase
    end

    // pin values follow the next state so every pin is a flip-flop
    always_comb
    begin
        in_cycle = (state_d == isa_cycle_pkg::ST_ADDR) || (state_d == isa_cycle_pkg::ST_CMD)
            || (state_d == isa_cycle_pkg::ST_END);
        aen_d = in_cycle && (dma_d || card_io_d); // R1 R4 R5
        // every cycle pulses latch enable, card and DMA included
        bale_d = (state_d == isa_cycle_pkg::ST_ADDR); // R6 R7
        ior_d = 1'b0;
        iow_d = 1'b0;
        memr_d = 1'b0;
        memw_d = 1'b0;
        dack_d = 2'b00;
        if (state_d == isa_cycle_pkg::ST_CMD && !dma_int_d)
        begin
            ior_d = (kind_d == isa_cycle_pkg::KIND_IO_RD); // R14
            iow_d = (kind_d == isa_cycle_pkg::KIND_IO_WR); // R15
            memr_d = (kind_d == isa_cycle_pkg::KIND_MEM_RD); // R17
            memw_d = (kind_d == isa_cycle_pkg::KIND_MEM_WR);
            dack_d[dma_chan_d] = dma_d; // R3
        end
        // upper lanes carry a byte on wide transfers or odd bytes of wide devices
        sbhe_d = in_cycle && (req_wide_d ? !phase_d : addr_d[0]); // R16
        if (state_d == isa_cycle_pkg::ST_CMD)
            sbhe_d = (req_wide_d && dev16_d) || (!req_wide_d && dev16_d && addr_d[0]); // R16
        sd_oe_d = in_cycle && !is_read(kind_d) && !dma_int_d;
        if (req_wide_d && !phase_d)
            sd_d = wdata_d;
        else if (req_wide_d)
            sd_d = {8'h00, wdata_d[15:8]};
        else
            sd_d = {wdata_d[7:0], wdata_d[7:0]};
        xoe_d = in_cycle && (i_local_bus_mode || i_dram32_mode); // R8
        // high direction turns inward on reads from wide devices or at odd addresses
        xdh_d = xoe_d && is_read(kind_d) && (dev16_d || addr_d[0]); // R9
        xdl_d = xoe_d && is_read(kind_d); // R9
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= isa_cycle_pkg::ST_IDLE;
            kind_q <= isa_cycle_pkg::KIND_MEM_RD;
            addr_q <= 26'h0000000;
            wdata_q <= 16'h0000;
            cnt_q <= '0;
            req_wide_q <= 1'b0;
            dev16_q <= 1'b0;
            phase_q <= 1'b0;
            dma_q <= 1'b0;
            dma_int_q <= 1'b0;
            dma_chan_q <= 1'b0;
            card_io_q <= 1'b0;
            aen_q <= 1'b0;
            bale_q <= 1'b0;
            ior_q <= 1'b0;
            iow_q <= 1'b0;
            memr_q <= 1'b0;
            memw_q <= 1'b0;
            sbhe_q <= 1'b0;
            dack_q <= 2'b00;
            sd_q <= 16'h0000;
            sd_oe_q <= 1'b0;
            xoe_q <= 1'b0;
            xdh_q <= 1'b0;
            xdl_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            kind_q <= kind_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            cnt_q <= cnt_d;
            req_wide_q <= req_wide_d;
            dev16_q <= dev16_d;
            phase_q <= phase_d;
            dma_q <= dma_d;
            dma_int_q <= dma_int_d;
            dma_chan_q <= dma_chan_d;
            card_io_q <= card_io_d;
            aen_q <= aen_d;
            bale_q <= bale_d;
            ior_q <= ior_d;
            iow_q <= iow_d;
            memr_q <= memr_d;
            memw_q <= memw_d;
            sbhe_q <= sbhe_d;
            dack_q <= dack_d;
            sd_q <= sd_d;
            sd_oe_q <= sd_oe_d;
            xoe_q <= xoe_d;
            xdh_q <= xdh_d;
            xdl_q <= xdl_d;
        end
    end

    rdata_store u_store
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(st_we && commands_on),
        .i_sel(st_sel),
        .i_wdata(st_byte),
        .i_we_both(st_we_both && commands_on),
        .i_wdata_both(i_sd),
        .o_rdata(o_rdata)
    );

    assign o_req_ready = (state_q == isa_cycle_pkg::ST_IDLE);
    assign o_done = (state_q == isa_cycle_pkg::ST_DONE);
    assign o_aen = aen_q;
    assign o_bale = bale_q;
    assign o_ior_n = !ior_q;
    assign o_iow_n = !iow_q;
    assign o_memr_n = !memr_q;
    assign o_memw_n = !memw_q;
    assign o_sbhe_n = !sbhe_q;
    assign o_prog_dma_ack_n = ~dack_q;
    assign o_sa = addr_q;
    assign o_sd = sd_q;
    assign o_sd_oe = sd_oe_q;
    assign o_xcvr_output_enable_n = !xoe_q;
    assign o_xcvr_dir_high_byte = xdh_q;
    assign o_xcvr_dir_low_byte = xdl_q;
endmodule

// ==== sim/isa_cycle_checker.sv ====
`timescale 1ns/1ps
`include "isa_cycle_defines.svh"

module isa_cycle_checker
(
    // clock, reset and request
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req_valid,
    input wire logic o_req_ready,
    input wire logic i_req_wide,
    input wire logic i_req_dma,
    input wire logic i_req_dma_internal,
    input wire logic i_req_card_io,
    input wire logic i_local_bus_mode,
    input wire logic i_dram32_mode,
    input wire logic i_iochrdy,
    // bus pins
    input wire logic o_aen,
    input wire logic o_bale,
    input wire logic o_ior_n,
    input wire logic o_iow_n,
    input wire logic o_memr_n,
    input wire logic o_memw_n,
    input wire logic o_sbhe_n,
    input wire logic [1:0] o_prog_dma_ack_n,
    input wire logic o_sd_oe,
    input wire logic o_xcvr_output_enable_n
);
    localparam int CMD_MIN = `CMD_MIN_CYCLES;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic cmd;
    logic take;
    logic aen_req;
    assign cmd = !(o_ior_n && o_iow_n && o_memr_n && o_memw_n);
    assign take = i_req_valid && o_req_ready;
    assign aen_req = i_req_dma || i_req_dma_internal || i_req_card_io;
    // cycles the current command has been low so far
    always_comb
    begin
        cnt_d = cmd ? cnt_q + 8'h01 : 8'h00;
    end
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_q <= 8'h00;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence addr_phase;
        o_bale ##1 !o_bale;
    endsequence
    sequence aen_take;
        take && aen_req;
    endsequence
    bale_pulse_a: assert property (take |=> addr_phase) else $error("latch pulse wrong");
    aen_dma_a: assert property (aen_take |=> o_aen) else $error("aen missing");
    aen_quiet_a: assert property (take && !aen_req |=> !o_aen [*8])
        else $error("aen on plain cycle");
    cmd_min_a: assert property (cnt_q != 8'h00 && !cmd |-> cnt_q >= CMD_MIN)
        else $error("command too short");
    wait_hold_a: assert property (cmd && !i_iochrdy && cnt_q >= CMD_MIN - 1 |=> cmd)
        else $error("wait not honoured");
    cmd_end_a: assert property (cmd && i_iochrdy && cnt_q >= CMD_MIN - 1 |=> !cmd)
        else $error("command overran");
    read_drive_a: assert property (!o_ior_n || !o_memr_n |-> !o_sd_oe)
        else $error("data driven on read");
    write_drive_a: assert property (!o_iow_n |-> o_sd_oe) else $error("write data absent");
    dack_aen_a: assert property (o_prog_dma_ack_n != 2'h3 |-> o_aen)
        else $error("dack without aen");
    xcvr_mode_a: assert property (!o_xcvr_output_enable_n |-> i_local_bus_mode || i_dram32_mode)
        else $error("transceiver outside modes");
    sbhe_wide_a: assert property (take && i_req_wide |=> !o_sbhe_n)
        else $error("high byte enable missing");
endmodule

bind isa_bus_cycle_control isa_cycle_checker chk_u (.i_clk, .i_rst, .i_req_valid, .o_req_ready,
    .i_req_wide, .i_req_dma, .i_req_dma_internal, .i_req_card_io, .i_local_bus_mode,
    .i_dram32_mode, .i_iochrdy, .o_aen, .o_bale, .o_ior_n, .o_iow_n, .o_memr_n, .o_memw_n,
    .o_sbhe_n, .o_prog_dma_ack_n, .o_sd_oe, .o_xcvr_output_enable_n);

// ==== sim/isa_periph_model.sv ====
`timescale 1ns/1ps

module isa_periph_model
(
    // clock and bus pins
    input wire logic i_clk,
    input wire logic i_aen,
    input wire logic i_bale,
    input wire logic i_ior_n,
    input wire logic i_iow_n,
    input wire logic i_memr_n,
    input wire logic i_memw_n,
    input wire logic [25:0] i_sa,
    input wire logic [15:0] i_sd,
    // device setup
    input wire logic i_io,
    input wire logic i_wide,
    input wire logic [3:0] i_waits,
    // answers
    output logic [15:0] o_sd,
    output logic o_iochrdy,
    output logic o_iocs16_n,
    output logic o_mem_wide_select_n,
    output logic [15:0] o_latched
);
    logic [7:0] cnt = 8'h00;
    logic [15:0] last = 16'h0000;
    logic mine;
    logic rd;
    logic wr;
    assign mine = i_io ? !i_aen : 1'b1;
    assign rd = mine && !(i_io ? i_ior_n : i_memr_n);
    assign wr = mine && !(i_io ? i_iow_n : i_memw_n);
    assign o_iocs16_n = !(i_io && mine && i_wide && (i_bale || rd || wr));
    assign o_mem_wide_select_n = !(!i_io && i_wide && (i_bale || rd || wr));
    // only ever pulled low; the pull-up gives high otherwise
    assign o_iochrdy = !((rd || wr) && i_waits != 4'h0 && cnt < 8'h13 + i_waits);
    // toggling pattern when released so a stale byte never looks valid
    assign o_sd = rd ? {i_sa[7:0] ^ 8'ha5, i_sa[7:0] ^ 8'h3c} : ~last;
    always @(posedge i_clk)
    begin
        cnt <= (rd || wr) ? cnt + 8'h01 : 8'h00;
        last <= o_sd;
        if (wr)
        begin
            o_latched <= i_sd;
        end
    end
endmodule

// ==== sim/test_isa_bus_cycle_control.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        tests_run++; \
        if ((g) !== (e)) \
        begin \
            bad_count++; \
            $display("mismatch %s exp %h got %h", nm, e, g); \
        end \
    end

module test_isa_bus_cycle_control;
    typedef struct {
        logic [1:0] kind;
        logic [15:0] addr;
        logic [15:0] wd;
        logic [7:0] ctl;
        logic [3:0] waits;
        logic [10:0] flags;
        int bales;
        logic [15:0] exp;
        logic [15:0] msk;
        int lat;
    } row_t;
    row_t rows [9];
    int bad_count = 0;
    int tests_run = 0;
    logic i_clk = 1'b0, i_rst = 1'b1, i_req_valid = 1'b0, i_req_wide = 1'b0, i_req_dma = 1'b0;
    logic i_req_dma_internal = 1'b0, i_req_dma_chan = 1'b0, i_req_card_io = 1'b0;
    logic i_local_bus_mode = 1'b0, i_dram32_mode = 1'b0, dev_io = 1'b0, dev_wide = 1'b0;
    logic [1:0] i_req_kind = 2'h0;
    logic [25:0] i_req_addr = 26'h0;
    logic [15:0] i_req_wdata = 16'h0000;
    logic [3:0] dev_waits = 4'h0;
    logic o_req_ready, o_done, o_aen, o_bale, o_ior_n, o_iow_n, o_memr_n, o_memw_n, o_sbhe_n;
    logic o_sd_oe, i_iochrdy, i_iocs16_n, i_mem_wide_select_n, o_xcvr_output_enable_n;
    logic o_xcvr_dir_high_byte, o_xcvr_dir_low_byte;
    logic [1:0] o_prog_dma_ack_n;
    logic [25:0] o_sa;
    logic [15:0] o_rdata, i_sd, o_sd, latched;

    isa_bus_cycle_control dut_u (.i_clk, .i_rst, .i_req_valid, .o_req_ready, .i_req_kind,
        .i_req_addr, .i_req_wdata, .i_req_wide, .i_req_dma, .i_req_dma_internal, .i_req_dma_chan,
        .i_req_card_io, .o_done, .o_rdata, .i_local_bus_mode, .i_dram32_mode, .o_aen, .o_bale,
        .o_ior_n, .o_iow_n, .o_memr_n, .o_memw_n, .o_sbhe_n, .o_prog_dma_ack_n, .o_sa, .i_sd,
        .o_sd, .o_sd_oe, .i_iochrdy, .i_iocs16_n, .i_mem_wide_select_n, .o_xcvr_output_enable_n,
        .o_xcvr_dir_high_byte, .o_xcvr_dir_low_byte);
    isa_periph_model periph_u (.i_clk, .i_aen(o_aen), .i_bale(o_bale), .i_ior_n(o_ior_n),
        .i_iow_n(o_iow_n), .i_memr_n(o_memr_n), .i_memw_n(o_memw_n), .i_sa(o_sa), .i_sd(o_sd),
        .i_io(dev_io), .i_wide(dev_wide), .i_waits(dev_waits), .o_sd(i_sd), .o_iochrdy(i_iochrdy),
        .o_iocs16_n(i_iocs16_n), .o_mem_wide_select_n(i_mem_wide_select_n), .o_latched(latched));

    always #2.5 i_clk = ~i_clk;

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic idle_chk();
        logic [12:0] pins;
        pins = {o_aen, o_bale, o_ior_n, o_iow_n, o_memr_n, o_memw_n, o_sbhe_n, o_prog_dma_ack_n,
            o_xcvr_output_enable_n, o_sd_oe, o_req_ready, o_done};
        `CHK("idle pins", 13'h07fa, pins)
        `CHK("idle addr", 26'h0000000, o_sa)
    endtask

    // ctl holds wide, dev wide, dma, internal, chan, card io, local bus, dram32
    task automatic run(input row_t r);
        int n;
        int b;
        logic [10:0] fl;
        n = 1;
        b = 0;
        fl = 11'h000;
        i_req_kind = r.kind;
        i_req_addr = {10'h000, r.addr};
        i_req_wdata = r.wd;
        {i_req_wide, dev_wide, i_req_dma, i_req_dma_internal, i_req_dma_chan, i_req_card_io,
            i_local_bus_mode, i_dram32_mode} = r.ctl;
        dev_io = r.kind[1];
        dev_waits = r.waits;
        i_req_valid = 1'b1;
        while (o_req_ready !== 1'b1)
        begin
            @(negedge i_clk);
        end
        @(negedge i_clk);
        i_req_valid = 1'b0;
        while (o_done !== 1'b1 && n < 200)
        begin
            fl |= {o_aen, ~o_ior_n, ~o_iow_n, ~o_memr_n, ~o_memw_n, ~o_prog_dma_ack_n,
                ~o_sbhe_n, ~o_xcvr_output_enable_n, o_xcvr_dir_high_byte, o_xcvr_dir_low_byte};
            b += int'(o_bale === 1'b1);
            @(negedge i_clk);
            n++;
        end
        `CHK("done", 1'b1, o_done)
        if (r.lat != 0)
            `CHK("cycles", r.lat, n)
        `CHK("flags", r.flags, fl)
        `CHK("bales", r.bales, b)
        `CHK("data", r.exp, (r.kind[0] ? latched : o_rdata) & r.msk)
    endtask

    initial
    begin
        rows[0] = '{2'h2, 16'h0100, 16'h0000, 8'hc0, 4'h0, 11'h208, 1, 16'ha53c, 16'hffff, 23};
        rows[1] = '{2'h3, 16'h0200, 16'h1234, 8'h00, 4'h0, 11'h100, 1, 16'h0034, 16'h00ff, 23};
        rows[2] = '{2'h0, 16'h3000, 16'h0000, 8'h80, 4'h0, 11'h088, 2, 16'h3d3c, 16'hffff, 45};
        rows[3] = '{2'h1, 16'h0400, 16'hbeef, 8'hc2, 4'h3, 11'h04c, 1, 16'hbeef, 16'hffff, 26};
        rows[4] = '{2'h0, 16'h4001, 16'h0000, 8'h41, 4'h0, 11'h08f, 1, 16'ha400, 16'hff00, 23};
        rows[5] = '{2'h1, 16'h0500, 16'h0077, 8'h28, 4'h0, 11'h460, 1, 16'h0077, 16'h00ff, 23};
        rows[6] = '{2'h1, 16'h0600, 16'h0000, 8'h10, 4'h0, 11'h400, 1, 16'h7777, 16'hffff, 23};
        rows[7] = '{2'h3, 16'h0300, 16'h0000, 8'h04, 4'h0, 11'h500, 1, 16'h7777, 16'hffff, 23};
        rows[8] = '{2'h3, 16'h0110, 16'hc0de, 8'hc0, 4'h1, 11'h108, 1, 16'hc0de, 16'hffff, 24};
        repeat (6) @(negedge i_clk);
        idle_chk();
        i_rst = 1'b0;
        foreach (rows[i])
        begin
            run(rows[i]);
        end
        // reset in the middle of a write must drop every strobe at once
        while (o_req_ready !== 1'b1)
        begin
            @(negedge i_clk);
        end
        i_req_kind = 2'h3;
        i_req_valid = 1'b1;
        @(negedge i_clk);
        i_req_valid = 1'b0;
        repeat (8) @(negedge i_clk);
        `CHK("mid write", 1'b0, o_iow_n)
        i_rst = 1'b1;
        @(negedge i_clk);
        idle_chk();
        i_rst = 1'b0;
        run(rows[0]);
        final_report();
    end

    // about 300 cycles of traffic expected, so 4000 is ample
    initial
    begin
        #20000;
        bad_count++;
        final_report();
    end
endmodule
